// ===== design/pss_sequencer.sv
// Purpose: instruction address counter, return stack, table read and data-memory map of the core
// Assumes: decoder drives op, skip and data-port inputs steady through the last phase of a cycle
// Notes: all instruction effects commit on the last phase of an instruction cycle; program store loads take effect on any clock
`timescale 1ns/1ps
module pss_sequencer (
  input wire logic ref_clk_i, // core clock, 20 MHz
  input wire logic sys_rst_i, // synchronous reset, active high
  input wire logic prog_wr_en_i, // program store load strobe
  input wire logic [12:0] prog_wr_addr_i, // program store load address
  input wire logic [15:0] prog_wr_data_i, // program store load word
  input wire logic page_option_i, // page select option enabled
  input wire pss_pkg::pss_op_e op_i, // decoded flow operation of current word
  input wire logic [12:0] op_target_i, // jump or call destination
  input wire logic skip_true_i, // skip condition met
  input wire logic [7:0] dm_addr_i, // data operand address
  input wire logic dm_wr_i, // byte write of dm_wdata_i
  input wire logic [7:0] dm_wdata_i, // write data
  input wire logic [1:0] dm_bit_op_i, // single-bit set or clear
  input wire logic [2:0] dm_bit_sel_i, // bit index for bit operations
  input wire logic irq_usb_i, // usb request pending and enabled
  input wire logic irq_tmr0_i, // timer 0 request pending and enabled
  input wire logic irq_tmr1_i, // timer 1 request pending and enabled
  output logic [15:0] instr_word_o, // word under execution
  output logic [12:0] instr_addr_o, // address of word under execution
  output logic instr_valid_o, // word is executing, not a dummy
  output logic [7:0] dm_rdata_o, // operand read data, one clock late
  output logic [2:0] irq_ack_o, // one-hot acknowledge: usb, tmr0, tmr1
  output logic stack_full_o // return stack holds eight entries
);

  // ----------------------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------------------
  logic [15:0] rom_mem [0:pss_pkg::ROM_WORDS-1];
  logic [7:0] ram_mem [0:pss_pkg::RAM_WORDS-1];
  logic [12:0] stk_mem [0:pss_pkg::STACK_DEPTH-1];
  logic [1:0] phase_q;
  pss_pkg::pss_slot_e slot_q;
  logic [12:0] pc_q;
  logic [12:0] cur_addr_q;
  logic [15:0] cur_word_q;
  logic [2:0] stk_wp_q;
  logic [3:0] stk_cnt_q;
  logic [7:0] mp0_q;
  logic [7:0] mp1_q;
  logic [7:0] lookup_pointer_low_q;
  logic [7:0] lookup_page_select_q;
  logic [7:0] lookup_result_high_q;
  logic [7:0] rdata_q;
  logic [2:0] irq_ack_q;

  logic commit;
  logic exec;
  logic is_tbl;
  logic stk_full;
  logic [7:0] ea;
  logic [7:0] old_val;
  logic [7:0] wr_val;
  logic wr_fire;
  logic code_jump;
  logic xfer;
  logic irq_any;
  logic irq_take;
  logic [12:0] irq_vec;
  logic [2:0] irq_sel;
  logic [12:0] lookup_addr;
  logic [15:0] lookup_word;
  logic [12:0] stk_top;
  logic push;
  logic pop;
  logic [12:0] pc_d;

  // ----------------------------------------------------------------------------
  // decode of the committing cycle
  // ----------------------------------------------------------------------------
  assign commit = (phase_q == pss_pkg::PHASE_LAST); // R23
  assign exec = commit && (slot_q == pss_pkg::SLOT_EXEC);
  assign is_tbl = (op_i == pss_pkg::OP_TBL_CUR) || (op_i == pss_pkg::OP_TBL_LAST);
  assign stk_full = (stk_cnt_q == pss_pkg::STACK_FULL_CNT);
  assign stk_top = stk_mem[3'(stk_wp_q - 3'h1)];

  // indirect slots redirect through the memory pointers
  always_comb begin
    if (dm_addr_i == pss_pkg::ADDR_IND0) begin
      ea = mp0_q; // R22
    end else if (dm_addr_i == pss_pkg::ADDR_IND1) begin
      ea = mp1_q; // R22
    end else begin
      ea = dm_addr_i;
    end
  end

  always_comb begin
    if (ea >= pss_pkg::RAM_BASE) begin
      old_val = ram_mem[8'(ea - pss_pkg::RAM_BASE)]; // R21
    end else begin
      case (ea)
        pss_pkg::ADDR_MP0: old_val = mp0_q;
        pss_pkg::ADDR_MP1: old_val = mp1_q;
        pss_pkg::ADDR_CODE_LOW: old_val = cur_addr_q[7:0];
        pss_pkg::ADDR_LOOKUP_PTR: old_val = lookup_pointer_low_q;
        pss_pkg::ADDR_LOOKUP_RES: old_val = lookup_result_high_q;
        pss_pkg::ADDR_LOOKUP_PAGE: old_val = lookup_page_select_q;
        default: old_val = 8'h00; // R20
      endcase
    end
  end

  // table location forming
  always_comb begin
    if (op_i == pss_pkg::OP_TBL_LAST) begin
      lookup_addr = {pss_pkg::LAST_PAGE, lookup_pointer_low_q}; // R12
    end else if (page_option_i) begin
      lookup_addr = {lookup_page_select_q[4:0], lookup_pointer_low_q}; // R11
    end else begin
      lookup_addr = {cur_addr_q[12:8], lookup_pointer_low_q}; // R10
    end
  end
  assign lookup_word = rom_mem[lookup_addr]; // R09

  always_comb begin
    if (exec && is_tbl) begin
      wr_val = lookup_word[7:0]; // R13
    end else if (dm_bit_op_i == pss_pkg::BIT_SET) begin
      wr_val = old_val | (8'h01 << dm_bit_sel_i); // R22
    end else if (dm_bit_op_i == pss_pkg::BIT_CLR) begin
      wr_val = old_val & ~(8'h01 << dm_bit_sel_i); // R22
    end else begin
      wr_val = dm_wdata_i;
    end
  end

  assign wr_fire = exec && (dm_wr_i || (dm_bit_op_i != pss_pkg::BIT_NONE) || is_tbl);
  assign code_jump = wr_fire && (ea == pss_pkg::ADDR_CODE_LOW); // R03

  // ----------------------------------------------------------------------------
  // flow control and interrupt entry
  // ----------------------------------------------------------------------------
  assign xfer = exec && ((op_i == pss_pkg::OP_JUMP) || (op_i == pss_pkg::OP_CALL) ||
                         (op_i == pss_pkg::OP_RET) || (op_i == pss_pkg::OP_INTERRUPT_RETURN_INSTR) ||
                         ((op_i == pss_pkg::OP_SKIP) && skip_true_i) || code_jump);
  assign irq_any = irq_usb_i || irq_tmr0_i || irq_tmr1_i;
  assign irq_take = exec && !xfer && !is_tbl && irq_any && !stk_full; // R18

  always_comb begin
    if (irq_usb_i) begin
      irq_vec = pss_pkg::VEC_USB; // R06 R24
      irq_sel = 3'h1;
    end else if (irq_tmr0_i) begin
      irq_vec = pss_pkg::VEC_TMR0; // R07
      irq_sel = 3'h2;
    end else begin
      irq_vec = pss_pkg::VEC_TMR1; // R08
      irq_sel = 3'h4;
    end
  end

  assign push = (exec && (op_i == pss_pkg::OP_CALL)) || irq_take; // R16
  assign pop = exec && ((op_i == pss_pkg::OP_RET) || (op_i == pss_pkg::OP_INTERRUPT_RETURN_INSTR)); // R16

  always_comb begin
    pc_d = 13'(pc_q + 13'h0001); // R01
    if (exec) begin
      case (op_i)
        pss_pkg::OP_JUMP, pss_pkg::OP_CALL: pc_d = op_target_i;
        pss_pkg::OP_RET, pss_pkg::OP_INTERRUPT_RETURN_INSTR: pc_d = stk_top; // R16
        default: pc_d = 13'(pc_q + 13'h0001);
      endcase
      if (code_jump) begin
        pc_d = {cur_addr_q[12:8], wr_val}; // R03
      end else if (irq_take) begin
        pc_d = irq_vec;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // cycle phase and slot sequencing
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= 2'(phase_q + 2'h1); // R23
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      slot_q <= pss_pkg::SLOT_DUMMY;
      pc_q <= pss_pkg::PC_RESET; // R05
      cur_addr_q <= pss_pkg::PC_RESET;
      cur_word_q <= 16'h0000;
    end else if (commit) begin
      case (slot_q)
        pss_pkg::SLOT_EXEC: begin
          if (xfer || irq_take) begin
            slot_q <= pss_pkg::SLOT_DUMMY; // R02 R04
            pc_q <= pc_d;
          end else if (is_tbl) begin
            slot_q <= pss_pkg::SLOT_TBL; // R14
          end else begin
            cur_word_q <= rom_mem[pc_q]; // R01
            cur_addr_q <= pc_q;
            pc_q <= pc_d;
          end
        end
        pss_pkg::SLOT_DUMMY, pss_pkg::SLOT_TBL: begin
          slot_q <= pss_pkg::SLOT_EXEC;
          cur_word_q <= rom_mem[pc_q];
          cur_addr_q <= pc_q;
          pc_q <= 13'(pc_q + 13'h0001); // R01
        end
        default: begin
          slot_q <= pss_pkg::SLOT_DUMMY;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      stk_wp_q <= 3'h0; // R17
      stk_cnt_q <= 4'h0;
    end else if (push) begin
      stk_mem[stk_wp_q] <= pc_q; // R16 R19
      stk_wp_q <= 3'(stk_wp_q + 3'h1);
      if (!stk_full) begin
        stk_cnt_q <= 4'(stk_cnt_q + 4'h1); // R15
      end
    end else if (pop) begin
      stk_wp_q <= 3'(stk_wp_q - 3'h1);
      if (stk_cnt_q != 4'h0) begin
        stk_cnt_q <= 4'(stk_cnt_q - 4'h1); // R18
      end
    end
  end

  // ----------------------------------------------------------------------------
  // program store and data memory
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (prog_wr_en_i) begin
      rom_mem[prog_wr_addr_i] <= prog_wr_data_i; // R09
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_fire && (ea >= pss_pkg::RAM_BASE)) begin
      ram_mem[8'(ea - pss_pkg::RAM_BASE)] <= wr_val; // R21
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mp0_q <= pss_pkg::REG_RESET;
      mp1_q <= pss_pkg::REG_RESET;
      lookup_pointer_low_q <= pss_pkg::REG_RESET;
      lookup_page_select_q <= pss_pkg::REG_RESET;
    end else if (wr_fire) begin
      case (ea)
        pss_pkg::ADDR_MP0: mp0_q <= wr_val;
        pss_pkg::ADDR_MP1: mp1_q <= wr_val;
        pss_pkg::ADDR_LOOKUP_PTR: lookup_pointer_low_q <= wr_val;
        pss_pkg::ADDR_LOOKUP_PAGE: lookup_page_select_q <= wr_val;
        default: begin
        end
      endcase
    end
  end

  // lookup result is loaded only by table reads
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      lookup_result_high_q <= pss_pkg::REG_RESET;
    end else if (exec && is_tbl) begin
      lookup_result_high_q <= lookup_word[15:8]; // R13
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
      irq_ack_q <= 3'h0;
    end else begin
      rdata_q <= old_val; // R20
      irq_ack_q <= irq_take ? irq_sel : 3'h0;
    end
  end

  assign instr_word_o = cur_word_q;
  assign instr_addr_o = cur_addr_q;
  assign instr_valid_o = (slot_q == pss_pkg::SLOT_EXEC);
  assign dm_rdata_o = rdata_q;
  assign irq_ack_o = irq_ack_q;
  assign stack_full_o = stk_full;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking chk_clk @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_phase_four_clk: assert property ( // R23
    (phase_q == 2'h0) |=> (phase_q == 2'h1) ##1 (phase_q == 2'h2) ##1 (phase_q == 2'h3) ##1 (phase_q == 2'h0))
    else $error("instruction cycle is not four clocks");

  chk_pc_increment: assert property ( // R01
    (commit && slot_q == pss_pkg::SLOT_DUMMY) |=> (pc_q == 13'($past(pc_q) + 13'h0001)) && (cur_addr_q == $past(pc_q)))
    else $error("fetch did not advance the counter by one");

  chk_skip_plus_two: assert property ( // R02
    (exec && op_i == pss_pkg::OP_SKIP && skip_true_i && !code_jump)
      |=> (slot_q == pss_pkg::SLOT_DUMMY) ##4 (cur_addr_q == 13'($past(cur_addr_q, 4) + 13'h0002)))
    else $error("skip did not land at address plus two");

  chk_code_low_jump: assert property ( // R03
    (code_jump && !irq_take) |=> (pc_q == {$past(cur_addr_q[12:8]), $past(wr_val)}))
    else $error("low byte write did not jump in page");

  chk_dummy_after_xfer: assert property ( // R04
    (xfer || irq_take) |=> (!instr_valid_o) [*4] ##1 instr_valid_o)
    else $error("control transfer without one dummy cycle");

  chk_reset_vector: assert property ( // R05
    disable iff (1'b0) sys_rst_i |=> (pc_q == pss_pkg::PC_RESET) && (stk_cnt_q == 4'h0))
    else $error("reset did not clear counter and stack");

  chk_usb_first: assert property ( // R24
    (irq_take && irq_usb_i) |=> (pc_q == pss_pkg::VEC_USB) && (irq_ack_o == 3'h1))
    else $error("usb request not vectored first");

  chk_tmr_vectors: assert property ( // R08
    (irq_take && !irq_usb_i && !irq_tmr0_i) |=> (pc_q == pss_pkg::VEC_TMR1) && (irq_ack_o == 3'h4))
    else $error("timer 1 request not vectored to its slot");

  chk_full_no_ack: assert property ( // R18
    (exec && stk_full && irq_any && op_i == pss_pkg::OP_NEXT && !code_jump)
      |=> (irq_ack_o == 3'h0) && stk_full && (pc_q == 13'($past(pc_q) + 13'h0001)))
    else $error("interrupt acknowledged on a full stack");

  chk_overflow_push: assert property ( // R19
    (exec && op_i == pss_pkg::OP_CALL && stk_full) |=> stk_full && (stk_wp_q == 3'($past(stk_wp_q) + 3'h1)))
    else $error("call on a full stack did not overwrite oldest entry");

  chk_table_two_cycle: assert property ( // R14
    (exec && is_tbl && !code_jump) |=> (slot_q == pss_pkg::SLOT_TBL) [*4] ##1 (slot_q == pss_pkg::SLOT_EXEC))
    else $error("table read did not take two cycles");

  chk_reserved_zero: assert property ( // R20
    (ea < pss_pkg::RAM_BASE && ea != pss_pkg::ADDR_MP0 && ea != pss_pkg::ADDR_MP1 && ea != pss_pkg::ADDR_CODE_LOW &&
     ea != pss_pkg::ADDR_LOOKUP_PTR && ea != pss_pkg::ADDR_LOOKUP_RES && ea != pss_pkg::ADDR_LOOKUP_PAGE)
      |=> (dm_rdata_o == 8'h00))
    else $error("reserved location did not read zero");

endmodule

// ===== design/pss_pkg.sv
// Purpose: constants and types of the program sequencer, return stack and table read block
// Assumes: one instruction cycle is four ref_clk_i periods
// Notes: data addresses are byte addresses of the 8-bit data memory space
// ----------------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------------
// Overview of operation
// [R01] Each fetch advances the instruction address counter by one.
// [R02] A true skip discards the prefetched word, runs a dummy cycle, continues at address plus two.
// [R03] Writing code_address_low_byte at 06H jumps within the current 256-word page.
// [R04] Jump, call, return, low byte write and interrupt entry add one dummy cycle.
// [R05] Reset loads the instruction address counter with 000H.
// [R06] Pending enabled USB interrupt with stack not full pushes and vectors to 004H.
// [R07] Taken timer 0 overflow interrupt with stack not full vectors to 008H.
// [R08] Taken timer 1 overflow interrupt with stack not full vectors to 00CH.
// [R09] Program store holds 8192 words of 16 bits, read by counter and table pointer.
// [R10] Page option off: current-page lookup uses counter bits 12..8 and pointer at 07H.
// [R11] Page option on: current-page lookup takes bits 12..8 from page select bits 4..0.
// [R12] Last-page lookup forces address bits 12..8 to ones.
// [R13] Lookup writes low byte to the operand, upper bits to read-only result at 08H.
// [R14] Every table read takes two instruction cycles.
// [R15] Return stack holds 8 addresses; entries and index are invisible to software.
// [R16] Call and interrupt entry push the address; both returns pop it.
// [R17] After reset the stack index points to the top with nothing held.
// [R18] With the stack full an enabled interrupt waits until a return pops.
// [R19] A call on a full stack still pushes and the oldest address is lost.
// [R20] Unimplemented special locations below 20H read as 00H.
// [R21] General-purpose storage spans data addresses 20H to FFH, read and write.
// [R22] Bits support single-bit set and clear; all memory reachable through both pointers.
// [R23] An instruction cycle lasts four system clock cycles.
// [R24] Simultaneous interrupts are serviced lowest vector first.
package pss_pkg;

  localparam int PC_W = 13;
  localparam int WORD_W = 16;
  localparam int ROM_WORDS = 8192;
  localparam int STACK_DEPTH = 8;
  localparam int RAM_WORDS = 224;

  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] VEC_USB = 13'h0004;
  localparam logic [12:0] VEC_TMR0 = 13'h0008;
  localparam logic [12:0] VEC_TMR1 = 13'h000C;
  localparam logic [4:0] LAST_PAGE = 5'h1F;
  localparam logic [3:0] STACK_FULL_CNT = 4'h8;

  localparam logic [7:0] ADDR_IND0 = 8'h00;
  localparam logic [7:0] ADDR_MP0 = 8'h01;
  localparam logic [7:0] ADDR_IND1 = 8'h02;
  localparam logic [7:0] ADDR_MP1 = 8'h03;
  localparam logic [7:0] ADDR_CODE_LOW = 8'h06;
  localparam logic [7:0] ADDR_LOOKUP_PTR = 8'h07;
  localparam logic [7:0] ADDR_LOOKUP_RES = 8'h08;
  localparam logic [7:0] ADDR_LOOKUP_PAGE = 8'h1F;
  localparam logic [7:0] RAM_BASE = 8'h20;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [1:0] BIT_NONE = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_CLR = 2'h2;

  typedef enum logic [2:0] {
    OP_NEXT,
    OP_SKIP,
    OP_JUMP,
    OP_CALL,
    OP_RET,
    OP_INTERRUPT_RETURN_INSTR,
    OP_TBL_CUR,
    OP_TBL_LAST
  } pss_op_e;

  typedef enum logic [1:0] {
    SLOT_EXEC,
    SLOT_DUMMY,
    SLOT_TBL
  } pss_slot_e;

endpackage

// ===== dv/pss_sequencer_test.sv
// Purpose: self-checking bench of the program sequencer, return stack and table read block
// Assumes: program store loaded between the first and second reset; inputs change on the falling edge
// Notes: bench keeps its own counter, stack and data map and compares at every executing cycle after the program load
`timescale 1ns/1ps
module pss_sequencer_test;
  // ----------------------------------------------------------------------------
  // signals and bench state
  // ----------------------------------------------------------------------------
  logic clk, rst = 1'b1, pw_en = 1'b0, popt = 1'b0, skp = 1'b0, dwr = 1'b0;
  logic [12:0] pw_a = 13'h0000, tgt = 13'h0000, ia, pc;
  logic [15:0] pw_d = 16'h0000, iw;
  logic [7:0] da = 8'h00, wd = 8'h00, rd;
  logic [1:0] bop = 2'h0, ph;
  logic [2:0] bsel = 3'h0, irq = 3'h0, ack, ack_log = 3'h0;
  logic iv, sf;
  pss_pkg::pss_op_e op = pss_pkg::OP_NEXT;
  logic [12:0] stk[$];
  logic [7:0] ref_dm[256];
  int n_mismatch = 0, n_checks = 0, cyc = 0, last = 0, exp_gap = -1;

  pss_sequencer u_dut (.ref_clk_i(clk), .sys_rst_i(rst), .prog_wr_en_i(pw_en), .prog_wr_addr_i(pw_a),
    .prog_wr_data_i(pw_d), .page_option_i(popt), .op_i(op), .op_target_i(tgt), .skip_true_i(skp),
    .dm_addr_i(da), .dm_wr_i(dwr), .dm_wdata_i(wd), .dm_bit_op_i(bop), .dm_bit_sel_i(bsel),
    .irq_usb_i(irq[0]), .irq_tmr0_i(irq[1]), .irq_tmr1_i(irq[2]), .instr_word_o(iw), .instr_addr_o(ia),
    .instr_valid_o(iv), .dm_rdata_o(rd), .irq_ack_o(ack), .stack_full_o(sf));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // phase follows the design: 0 in reset, commit on the edge that ends phase 3
  always @(posedge clk) begin
    ph <= rst ? 2'h0 : ph + 2'h1;
    cyc <= cyc + 1;
    if (ack !== 3'h0) ack_log <= ack_log | ack;
  end

  // ----------------------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------------------
  function automatic logic [15:0] word_of(input logic [12:0] a);
    return {a[7:0], a[12:5]} ^ 16'hC35A;
  endfunction

  function automatic logic [7:0] resolve(input logic [7:0] a);
    return a == 8'h00 ? ref_dm[1] : a == 8'h02 ? ref_dm[3] : a;
  endfunction

  function automatic logic writable(input logic [7:0] r);
    return r == 8'h01 || r == 8'h03 || r == 8'h07 || r == 8'h1F || r >= 8'h20;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic push();
    if (stk.size() == 8) void'(stk.pop_front());
    stk.push_back(pc + 13'h1);
  endtask

  // ----------------------------------------------------------------------------
  // one instruction: wait for an executing phase 3, drive, update the model
  // ----------------------------------------------------------------------------
  task automatic do_op(input pss_pkg::pss_op_e o, input logic [12:0] t, input logic s, input logic [7:0] a,
                       input logic wv, input logic [7:0] d, input logic [1:0] b, input logic [2:0] bs);
    logic [7:0] r;
    logic [15:0] tw;
    while (!(ph == 2'h3 && iv === 1'b1) && cyc - last < 20) begin
      @(negedge clk);
    end
    if (exp_gap >= 0) chk(16'(cyc - last), 16'(exp_gap));
    chk({3'h0, ia}, {3'h0, pc});
    chk(iw, word_of(pc));
    chk({15'h0, sf}, {15'h0, stk.size() == 8});
    op = o;
    tgt = t;
    skp = s;
    da = a;
    dwr = wv;
    wd = d;
    bop = b;
    bsel = bs;
    @(negedge clk);
    last = cyc;
    op = pss_pkg::OP_NEXT;
    skp = 1'b0;
    dwr = 1'b0;
    bop = pss_pkg::BIT_NONE;
    r = resolve(a);
    exp_gap = 7;
    if (o == pss_pkg::OP_TBL_CUR || o == pss_pkg::OP_TBL_LAST) begin
      tw = word_of(o == pss_pkg::OP_TBL_LAST ? {5'h1F, ref_dm[7]} :
                   popt ? {ref_dm[31][4:0], ref_dm[7]} : {pc[12:8], ref_dm[7]});
      if (writable(r)) ref_dm[r] = tw[7:0];
      ref_dm[8] = tw[15:8];
      pc = pc + 13'h1;
    end else if (o == pss_pkg::OP_SKIP && s) begin
      pc = pc + 13'h2;
    end else if (o == pss_pkg::OP_JUMP) begin
      pc = t;
    end else if (o == pss_pkg::OP_CALL) begin
      push();
      pc = t;
    end else if (o == pss_pkg::OP_RET || o == pss_pkg::OP_INTERRUPT_RETURN_INSTR) begin
      pc = stk.pop_back();
    end else if (wv && r == 8'h06) begin
      pc = {pc[12:8], d};
    end else if (irq != 3'h0 && stk.size() < 8) begin
      push();
      pc = irq[0] ? 13'h0004 : irq[1] ? 13'h0008 : 13'h000C;
    end else begin
      pc = pc + 13'h1;
      exp_gap = 3;
    end
    if (wv && writable(r)) ref_dm[r] = d;
    if (b == pss_pkg::BIT_SET && writable(r)) ref_dm[r][bs] = 1'b1;
    if (b == pss_pkg::BIT_CLR && writable(r)) ref_dm[r][bs] = 1'b0;
  endtask

  task automatic nxt();
    do_op(pss_pkg::OP_NEXT, 13'h0, 1'b0, 8'h20, 1'b0, 8'h00, pss_pkg::BIT_NONE, 3'h0);
  endtask

  task automatic fl(input pss_pkg::pss_op_e o, input logic [12:0] t, input logic s);
    do_op(o, t, s, 8'h20, 1'b0, 8'h00, pss_pkg::BIT_NONE, 3'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    do_op(pss_pkg::OP_NEXT, 13'h0, 1'b0, a, 1'b1, d, pss_pkg::BIT_NONE, 3'h0);
  endtask

  // at most three reads between two instructions, so no cycle goes untracked
  task automatic rchk(input logic [7:0] a);
    logic [7:0] r;
    r = resolve(a);
    da = a;
    @(negedge clk);
    chk({8'h0, rd}, {8'h0, r == 8'h06 ? pc[7:0] : ref_dm[r]});
  endtask

  task automatic take(input logic [2:0] e);
    ack_log = 3'h0;
    nxt();
    repeat (2) @(negedge clk);
    chk({13'h0, ack_log}, {13'h0, e});
    irq = irq & ~e;
  endtask

  task automatic do_rst();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    chk({3'h0, ia}, 16'h0000);
    chk({14'h0, sf, iv}, 16'h0000);
    rst = 1'b0;
    pc = 13'h0000;
    stk.delete();
    exp_gap = -1;
    last = cyc;
    ref_dm[1] = 8'h00;
    ref_dm[3] = 8'h00;
    ref_dm[7] = 8'h00;
    ref_dm[8] = 8'h00;
    ref_dm[31] = 8'h00;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [7:0] a;
    int k;
    void'($urandom(32'h89929DAF));
    foreach (ref_dm[i]) ref_dm[i] = 8'h00;
    do_rst();
    for (int i = 0; i < pss_pkg::ROM_WORDS; i++) begin
      pw_en = 1'b1;
      pw_a = i[12:0];
      pw_d = word_of(i[12:0]);
      @(negedge clk);
    end
    pw_en = 1'b0;
    do_rst();
    for (int i = 32; i < 256; i++) wr(i[7:0], 8'($urandom));
    fl(pss_pkg::OP_SKIP, 13'h0, 1'b1);
    fl(pss_pkg::OP_SKIP, 13'h0, 1'b0);
    wr(8'h06, 8'hFF);
    nxt();
    rchk(8'h06);
    for (int i = 0; i < 32; i++) begin
      if (i == 0 || i == 2 || i == 6) nxt();
      else wr(i[7:0], 8'($urandom));
      rchk(i[7:0]);
    end
    repeat (8) begin
      a = 8'($urandom_range(32, 255));
      wr(8'h01, a);
      wr(8'h00, 8'($urandom));
      rchk(a);
      wr(8'h03, a);
      do_op(pss_pkg::OP_NEXT, 13'h0, 1'b0, 8'h02, 1'b0, 8'h00, 2'($urandom_range(1, 2)), 3'($urandom));
      rchk(a);
      rchk(8'h02);
    end
    repeat (80) begin
      k = $urandom_range(0, 5);
      if (k == 0) fl(pss_pkg::OP_SKIP, 13'h0, 1'($urandom));
      else if (k == 1) fl(pss_pkg::OP_JUMP, 13'($urandom), 1'b0);
      else if (k == 2 && stk.size() < 7) fl(pss_pkg::OP_CALL, 13'($urandom), 1'b0);
      else if (k == 3 && stk.size() > 0)
        fl(pss_pkg::pss_op_e'($urandom_range(0, 1) ? pss_pkg::OP_RET : pss_pkg::OP_INTERRUPT_RETURN_INSTR), 13'h0, 1'b0);
      else if (k == 4) wr(8'h06, 8'($urandom));
      else nxt();
    end
    while (stk.size() > 0) fl(pss_pkg::OP_RET, 13'h0, 1'b0);
    for (int i = 0; i < 6; i++) begin
      popt = (i % 3 == 1);
      wr(8'h07, 8'($urandom));
      wr(8'h1F, 8'($urandom));
      a = 8'($urandom_range(32, 255));
      do_op(pss_pkg::pss_op_e'(i % 3 == 2 ? pss_pkg::OP_TBL_LAST : pss_pkg::OP_TBL_CUR),
            13'h0, 1'b0, a, 1'b0, 8'h00, pss_pkg::BIT_NONE, 3'h0);
      rchk(a);
      rchk(8'h08);
    end
    irq = 3'h7;
    take(3'h1);
    take(3'h2);
    take(3'h4);
    repeat (3) fl(pss_pkg::OP_INTERRUPT_RETURN_INSTR, 13'h0, 1'b0);
    for (int i = 0; i < 9; i++) fl(pss_pkg::OP_CALL, 13'($urandom), 1'b0);
    irq = 3'h1;
    ack_log = 3'h0;
    nxt();
    nxt();
    chk({13'h0, ack_log}, 16'h0000);
    fl(pss_pkg::OP_RET, 13'h0, 1'b0);
    take(3'h1);
    fl(pss_pkg::OP_INTERRUPT_RETURN_INSTR, 13'h0, 1'b0);
    while (stk.size() > 0) fl(pss_pkg::OP_RET, 13'h0, 1'b0);
    repeat (3) fl(pss_pkg::OP_CALL, 13'($urandom), 1'b0);
    do_rst();
    nxt();
    rchk(8'h07);
    rchk(8'h1F);
    test_done();
  end
endmodule
